//--- hdl/ird_top.sv
// Bus-facing wrapper storing decoded remote frames
`timescale 1ns/100ps
`default_nettype none
module ird_top #(
  parameter int unsigned LEAD_ON_MIN = ird_pkg::LEAD_ON_MIN_CYC,
  parameter int unsigned LEAD_OFF_MIN = ird_pkg::LEAD_OFF_MIN_CYC,
  parameter int unsigned BIT_TH = ird_pkg::BIT_TH_CYC,
  parameter int unsigned TIMEOUT = ird_pkg::TIMEOUT_CYC
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic ir_n_i,
  input wire logic bus_sel_i,
  input wire logic bus_rd_i,
  input wire logic [ird_pkg::ADDR_W-1:0] bus_addr_i,
  output logic [ird_pkg::DATA_W-1:0] bus_rdata_o,
  output logic irq_o
);
  import ird_pkg::*;
  logic rx_done;
  logic [DATA_W-1:0] rx_data;
  logic [DATA_W-1:0] frame_q, frame_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic irq_q, irq_d;
  logic [KEY_W-1:0] rx_key, rx_inv;
  logic frame_ok, accept, rd_hit;

  // Decoding lives in the receiver; this level checks the inverted key and stores
  ird_rx #(
    .LEAD_ON_MIN(LEAD_ON_MIN),
    .LEAD_OFF_MIN(LEAD_OFF_MIN),
    .BIT_TH(BIT_TH),
    .TIMEOUT(TIMEOUT)
  ) u_rx (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .ir_n_i(ir_n_i),
    .done_o(rx_done),
    .data_o(rx_data)
  );

  assign rx_key = rx_data[KEY_LSB +: KEY_W];
  assign rx_inv = rx_data[INV_LSB +: KEY_W];
  assign frame_ok = (rx_inv == ~rx_key);
  assign accept = rx_done & frame_ok;
  assign rd_hit = bus_sel_i & bus_rd_i & (bus_addr_i == FRAME_OFS);

  always_comb begin
    frame_d = frame_q;
    // Inverted key, key and custom fields in one word
    if (accept) frame_d = rx_data;
    // Unmapped addresses read as zero
    rdata_d = rd_hit ? frame_q : '0;
    // A new frame in the read cycle keeps the request raised
    irq_d = accept ? 1'b1 : (rd_hit ? 1'b0 : irq_q);
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      frame_q <= FRAME_RST;
      rdata_q <= '0;
      irq_q <= 1'b0;
    end else begin
      frame_q <= frame_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
    end
  end

  assign bus_rdata_o = rdata_q;
  assign irq_o = irq_q;

  // Checks
  a_latch_frame: assert property (@(posedge mclk_i) disable iff (reset_i)
    accept |=> (frame_q == $past(rx_data)) && irq_q)
    else $error("frame not latched with interrupt");
  a_drop_bad: assert property (@(posedge mclk_i) disable iff (reset_i)
    (rx_done && !frame_ok) |=> $stable(frame_q))
    else $error("bad frame changed register");
  a_inv_compl: assert property (@(posedge mclk_i) disable iff (reset_i)
    $changed(frame_q) |-> (frame_q[INV_LSB +: KEY_W] == ~frame_q[KEY_LSB +: KEY_W]))
    else $error("stored inverted key not complement");
  a_field_map: assert property (@(posedge mclk_i) disable iff (reset_i)
    accept |=> frame_q[CUST_LSB +: CUST_W] == $past(rx_data[CUST_LSB +: CUST_W])
      && frame_q[KEY_LSB +: KEY_W] == $past(rx_key))
    else $error("field placement wrong");
  a_read_data: assert property (@(posedge mclk_i) disable iff (reset_i)
    rd_hit |=> bus_rdata_o == $past(frame_q))
    else $error("read data wrong");
  a_unmapped: assert property (@(posedge mclk_i) disable iff (reset_i)
    !rd_hit |=> bus_rdata_o == '0)
    else $error("unmapped read not zero");
  a_irq_hold: assert property (@(posedge mclk_i) disable iff (reset_i)
    (irq_q && !rd_hit && !accept) |=> irq_q)
    else $error("interrupt dropped without read");
  a_irq_clear: assert property (@(posedge mclk_i) disable iff (reset_i)
    (rd_hit && !accept) ##1 !accept |-> !irq_q ##1 !irq_q)
    else $error("interrupt not cleared by read");
  a_no_spur_irq: assert property (@(posedge mclk_i) disable iff (reset_i)
    (!irq_q && !accept) |=> !irq_q)
    else $error("interrupt without frame");
  a_digit_order: assert property (@(posedge mclk_i) disable iff (reset_i)
    (accept && rx_key <= 8'h09) |=> frame_q[INV_LSB +: KEY_W] >= 8'hf6)
    else $error("digit key byte order wrong");
  c_good_frame: cover property (@(posedge mclk_i) disable iff (reset_i) accept);
  c_bad_frame: cover property (@(posedge mclk_i) disable iff (reset_i) rx_done && !frame_ok);
  c_read_irq: cover property (@(posedge mclk_i) disable iff (reset_i) irq_q && rd_hit);
  c_set_on_clr: cover property (@(posedge mclk_i) disable iff (reset_i) accept && rd_hit);
endmodule : ird_top
`default_nettype wire

//--- hdl/ird_pkg.sv
// Constants for the infrared remote frame decoder
package ird_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 2;
  localparam logic [ADDR_W-1:0] FRAME_OFS = 2'h0;
  localparam logic [DATA_W-1:0] FRAME_RST = 32'h0000_0000;
  localparam int unsigned INV_LSB = 24;
  localparam int unsigned KEY_LSB = 16;
  localparam int unsigned CUST_LSB = 0;
  localparam int unsigned CUST_W = 16;
  localparam int unsigned KEY_W = 8;
  localparam int unsigned CLK_MHZ = 25;
  localparam int unsigned LEAD_ON_US = 9000;
  localparam int unsigned LEAD_OFF_US = 4500;
  localparam int unsigned ZERO_GAP_US = 560;
  localparam int unsigned ONE_GAP_US = 1690;
  // Leader phases accepted from half their nominal length
  localparam int unsigned LEAD_ON_MIN_CYC = LEAD_ON_US * CLK_MHZ / 2;
  localparam int unsigned LEAD_OFF_MIN_CYC = LEAD_OFF_US * CLK_MHZ / 2;
  // Gap above the midpoint of 560 us and 1690 us is a one
  localparam int unsigned BIT_TH_CYC = (ZERO_GAP_US + ONE_GAP_US) * CLK_MHZ / 2;
  // Longest quiet phase is the leader gap; twice it still fits the counter
  localparam int unsigned TIMEOUT_CYC = 2 * LEAD_OFF_US * CLK_MHZ;
  localparam int unsigned CNT_W = 18;
endpackage : ird_pkg

//--- hdl/ird_rx.sv
// Pulse-distance receiver extracting one 32-bit remote frame
`timescale 1ns/100ps
`default_nettype none
module ird_rx #(
  parameter int unsigned LEAD_ON_MIN = ird_pkg::LEAD_ON_MIN_CYC,
  parameter int unsigned LEAD_OFF_MIN = ird_pkg::LEAD_OFF_MIN_CYC,
  parameter int unsigned BIT_TH = ird_pkg::BIT_TH_CYC,
  parameter int unsigned TIMEOUT = ird_pkg::TIMEOUT_CYC
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic ir_n_i,
  output logic done_o,
  output logic [ird_pkg::DATA_W-1:0] data_o
);
  import ird_pkg::*;
  typedef enum logic [2:0] {IDLE, LEAD_ON, LEAD_OFF, BIT_ON, BIT_OFF} ird_rx_e;
  ird_rx_e st_q, st_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [5:0] nbit_q, nbit_d;
  logic [DATA_W-1:0] sh_q, sh_d;
  logic done_q, done_d;
  logic carrier_q, carrier_d;
  logic rise, fall, tmo;

  assign carrier_d = ~ir_n_i;
  assign rise = carrier_d & ~carrier_q;
  assign fall = ~carrier_d & carrier_q;
  assign tmo = cnt_q >= CNT_W'(TIMEOUT);
  assign done_o = done_q;
  assign data_o = sh_q;

  always_comb begin
    st_d = st_q;
    nbit_d = nbit_q;
    sh_d = sh_q;
    done_d = 1'b0;
    cnt_d = (rise || fall) ? '0 : (&cnt_q ? cnt_q : cnt_q + 1'b1);
    case (st_q)
      IDLE: begin
        if (rise) st_d = LEAD_ON;
      end
      LEAD_ON: begin
        if (fall) st_d = (cnt_q >= CNT_W'(LEAD_ON_MIN)) ? LEAD_OFF : IDLE;
      end
      LEAD_OFF: begin
        if (rise) begin
          st_d = (cnt_q >= CNT_W'(LEAD_OFF_MIN)) ? BIT_ON : IDLE;
          nbit_d = '0;
        end else if (tmo) begin
          st_d = IDLE;
        end
      end
      BIT_ON: begin
        if (fall) st_d = BIT_OFF;
        else if (tmo) st_d = IDLE;
      end
      BIT_OFF: begin
        if (rise) begin
          sh_d = {cnt_q >= CNT_W'(BIT_TH), sh_q[DATA_W-1:1]};
          nbit_d = nbit_q + 1'b1;
          if (nbit_q == 6'(DATA_W - 1)) begin
            done_d = 1'b1;
            st_d = IDLE;
          end else begin
            st_d = BIT_ON;
          end
        end else if (tmo) begin
          st_d = IDLE;
        end
      end
      default: st_d = IDLE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      st_q <= IDLE;
      cnt_q <= '0;
      nbit_q <= '0;
      sh_q <= '0;
      done_q <= 1'b0;
      carrier_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      nbit_q <= nbit_d;
      sh_q <= sh_d;
      done_q <= done_d;
      carrier_q <= carrier_d;
    end
  end
endmodule : ird_rx
`default_nettype wire

//--- test/ird_remote.sv
// Behavioural remote module driving demodulated frames
`timescale 1ns/100ps
`default_nettype none
module ird_remote #(
  parameter int LEAD_ON = 50, LEAD_OFF = 30, BURST = 7, GAP0 = 6, GAP1 = 18
) (
  input wire logic mclk_i,
  output logic ir_n_o
);
  initial ir_n_o = 1'b1;
  task automatic seg(input logic carrier, input int n);
    ir_n_o = ~carrier;
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : seg
  task automatic send(input logic [31:0] w);
    seg(1'b1, LEAD_ON);
    seg(1'b0, LEAD_OFF);
    for (int i = 0; i < 32; i++) begin
      seg(1'b1, BURST);
      seg(1'b0, w[i] ? GAP1 : GAP0);
    end
    seg(1'b1, BURST);
    ir_n_o = 1'b1;
  endtask : send
endmodule : ird_remote
`default_nettype wire

//--- test/tb_top.sv
// Self-checking bench for the infrared frame decoder
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import ird_pkg::*;
  localparam logic [15:0] CUST = 16'h5a3c; // Arbitrary custom code
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic ir_n;
  logic bus_sel = 1'b0;
  logic bus_rd = 1'b0;
  logic [ADDR_W-1:0] bus_addr = '0;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] last;
  logic irq;
  int n_fail = 0;
  int compares = 0;
  int cyc = 0;
  initial forever #20 mclk_i = ~mclk_i;
  ird_remote u_rem (.mclk_i(mclk_i), .ir_n_o(ir_n));
  ird_top #(.LEAD_ON_MIN(40), .LEAD_OFF_MIN(20), .BIT_TH(10), .TIMEOUT(60)) u_dut (
    .mclk_i(mclk_i), .reset_i(reset_i), .ir_n_i(ir_n), .bus_sel_i(bus_sel),
    .bus_rd_i(bus_rd), .bus_addr_i(bus_addr), .bus_rdata_o(rdata), .irq_o(irq));
  function automatic logic [31:0] frame(input logic [7:0] k, input logic [7:0] inv);
    return {inv, k, CUST};
  endfunction : frame
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
    @(posedge mclk_i);
    #1;
    bus_sel = 1'b1;
    bus_rd = 1'b1;
    bus_addr = a;
    @(posedge mclk_i);
    #1;
    bus_sel = 1'b0;
    bus_rd = 1'b0;
    d = rdata;
  endtask : rd
  task automatic frame_test(input logic [7:0] k, input logic [7:0] inv);
    logic [31:0] d;
    int w;
    @(posedge mclk_i);
    #1;
    u_rem.send(frame(k, inv));
    w = 0;
    while (irq !== 1'b1 && w < 20) begin
      @(posedge mclk_i);
      w++;
    end
    if (inv === ~k) begin
      chk(irq, 1);
      last = frame(k, inv);
    end else begin
      chk(irq, 0);
    end
    rd(FRAME_OFS, d);
    chk(d, last);
    chk(irq, 0);
  endtask : frame_test
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc > 30000) begin
      n_fail++;
      end_of_test();
    end
  end
  initial begin
    logic [31:0] d;
    logic [7:0] k;
    void'($urandom(32'h7cf867e7));
    last = FRAME_RST;
    repeat (10) @(posedge mclk_i);
    #1;
    reset_i = 1'b0;
    rd(FRAME_OFS, d);
    chk(d, FRAME_RST);
    chk(irq, 0);
    for (int i = 0; i < 10; i++) frame_test(8'(i), ~8'(i));
    repeat (4) begin
      k = 8'($urandom);
      frame_test(k, ~k);
    end
    frame_test(8'h5a, 8'h5a);
    k = 8'($urandom);
    frame_test(k, ~k ^ 8'h10);
    for (int a = 1; a < 4; a++) begin
      rd(2'(a), d);
      chk(d, 0);
    end
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
